// ==== usart_clk_frame_pkg.sv ====
// constants, types and register layout for the usart clock and frame block
package usart_clk_frame_pkg;

  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned DIV_W  = 12;
  localparam int unsigned CHAR_W = 9;

  // register offsets
  localparam logic [2:0] ADDR_DIV_LOW  = 3'h0;
  localparam logic [2:0] ADDR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADDR_CSA      = 3'h2;
  localparam logic [2:0] ADDR_CSB      = 3'h3;
  localparam logic [2:0] ADDR_CSC      = 3'h4;
  localparam logic [2:0] ADDR_SDR      = 3'h5;
  localparam logic [2:0] ADDR_PIN_DIR  = 3'h6;

  // control_status_a fields
  localparam int unsigned CSA_RXC   = 7;
  localparam int unsigned CSA_TXC   = 6;
  localparam int unsigned CSA_EMPTY = 5;
  localparam int unsigned CSA_FE    = 4;
  localparam int unsigned CSA_PE    = 2;
  localparam int unsigned CSA_U2X   = 1;
  // control_status_b fields
  localparam int unsigned CSB_RXEN  = 4;
  localparam int unsigned CSB_TXEN  = 3;
  localparam int unsigned CSB_CS2   = 2;
  localparam int unsigned CSB_RXB8  = 1;
  localparam int unsigned CSB_TXB8  = 0;
  // control_status_c fields
  localparam int unsigned CSC_SYNC  = 6;
  localparam int unsigned CSC_PM1   = 5;
  localparam int unsigned CSC_PM0   = 4;
  localparam int unsigned CSC_STOP  = 3;
  localparam int unsigned CSC_CS1   = 2;
  localparam int unsigned CSC_CS0   = 1;
  localparam int unsigned CSC_POL   = 0;
  // xfer_clock_pin_direction field
  localparam int unsigned PIN_DIR_BIT = 0;

  // values after reset
  localparam logic [2:0]  CHAR_SIZE_RST = 3'h6;
  localparam logic [11:0] DIVISOR_RST   = 12'h000;

  // encodings
  localparam logic [2:0] CS_NINE    = 3'h7;
  localparam logic [1:0] PM_EVEN    = 2'h2;
  localparam logic [1:0] PM_ODD     = 2'h3;

  // cycle counts of the dividers and sample points
  localparam logic [3:0] OS_LAST_NORMAL = 4'hF;
  localparam logic [3:0] OS_LAST_DOUBLE = 4'h7;
  localparam logic [3:0] OS_MID_NORMAL  = 4'h7;
  localparam logic [3:0] OS_MID_DOUBLE  = 4'h3;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_START = 3'b001,
    TX_DATA  = 3'b010,
    TX_PAR   = 3'b011,
    TX_STOP1 = 3'b100,
    TX_STOP2 = 3'b101
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } rx_state_t;

  typedef struct packed {
    logic       sync_select;
    logic       double_speed;
    logic       xfer_clock_pin_direction;
    logic       sync_clock_polarity;
    logic [2:0] character_size;
    logic [1:0] parity_mode;
    logic       stop_select;
  } frame_cfg_t;

endpackage

// ==== usart_baud_gen.sv ====
// twelve bit baud down-counter with reload on zero or on request
`timescale 1ns/100ps
`default_nettype none
module usart_baud_gen
  import usart_clk_frame_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic [DIV_W-1:0] divisor_in,
  input  wire logic             reload_in,
  output logic                  tick_out
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } baud_state_t;

  baud_state_t s_r;
  baud_state_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (reload_in || s_r.cnt == '0) begin
      s_nxt.cnt = divisor_in;
    end else begin
      s_nxt.cnt = s_r.cnt - 12'h001;
    end
  end

  assign tick_out = (s_r.cnt == '0);

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      s_r <= '{cnt: DIVISOR_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
`default_nettype wire

// ==== usart_clk_frame.sv ====
// usart clock generation, frame transmit and frame receive logic
`timescale 1ns/100ps
`default_nettype none
module usart_clk_frame
  import usart_clk_frame_pkg::*;
(
  input  wire logic              CLK_IN,
  input  wire logic              RSTN_IN,
  input  wire logic [ADDR_W-1:0] ADDR_IN,
  input  wire logic [DATA_W-1:0] WDATA_IN,
  input  wire logic              WR_IN,
  input  wire logic              RD_IN,
  input  wire logic              RXD_IN,
  input  wire logic              XCK_IN,
  output logic [DATA_W-1:0]      RDATA_OUT,
  output logic                   TXD_OUT,
  output logic                   XCK_OUT,
  output logic                   XCK_OE_OUT
);

  typedef struct packed {
    frame_cfg_t        cfg;
    logic              tx_en;
    logic              rx_en;
    logic              tx_b8;
    logic [3:0]        div_high;
    logic [7:0]        div_low;
    logic [CHAR_W-1:0] tx_buf;
    logic              tx_full;
    logic [CHAR_W-1:0] tx_shift;
    logic              tx_parbit;
    tx_state_t         tx_state;
    logic [3:0]        tx_bit;
    logic [3:0]        presc;
    logic              txd;
    logic              transmit_complete_flag;
    logic              transfer_clock_pin;
    logic              xck_oe;
    logic              ext_s1;
    logic              ext_s2;
    logic              ext_prev;
    rx_state_t         rx_state;
    logic [3:0]        rx_os;
    logic [3:0]        rx_bit;
    logic [CHAR_W-1:0] rx_shift;
    logic              rx_par;
    logic [CHAR_W-1:0] rx_data;
    logic              receive_complete_flag;
    logic              fe;
    logic              pe;
    logic [7:0]        rdata;
  } core_state_t;

  core_state_t s_r;
  core_state_t s_nxt;
  logic        baud_tick;
  logic        div_reload;
  logic        os_double;
  logic        sync_master;
  logic        sync_slave;
  logic        ext_rise;
  logic        ext_fall;
  logic        chg_edge;
  logic        smp_edge;
  logic        tx_tick;
  logic        rx_samp;
  logic [3:0]  os_last;
  logic [3:0]  os_mid;
  logic [3:0]  nbits;
  logic [7:0]  rd_val;
  logic [CHAR_W-1:0] rx_aligned;

  function automatic logic [3:0] data_bits(input logic [2:0] cs);
    if (cs == CS_NINE) begin
      data_bits = 4'h9;
    end else begin
      data_bits = {2'b00, cs[1:0]} + 4'h5;
    end
  endfunction

  function automatic logic parity_of(input logic [CHAR_W-1:0] d,
                                     input logic [3:0] n,
                                     input logic [1:0] pm);
    logic [CHAR_W-1:0] mask;
    mask = 9'h1FF >> (4'h9 - n);
    parity_of = (^(d & mask)) ^ (pm == PM_ODD);
  endfunction

  function automatic logic parity_on(input logic [1:0] pm);
    parity_on = pm[1];
  endfunction

  assign div_reload = WR_IN && (ADDR_IN == ADDR_DIV_LOW);

  usart_baud_gen u_baud (
    .clk_in     (CLK_IN),
    .rstn_in    (RSTN_IN),
    .divisor_in ({s_nxt.div_high, s_nxt.div_low}),
    .reload_in  (div_reload),
    .tick_out   (baud_tick)
  );

  always_comb begin
    s_nxt = s_r;
    rd_val = 8'h00;
    sync_master = s_r.cfg.sync_select && s_r.cfg.xfer_clock_pin_direction;
    sync_slave  = s_r.cfg.sync_select && !s_r.cfg.xfer_clock_pin_direction;
    os_double = s_r.cfg.double_speed && !s_r.cfg.sync_select;
    os_last = os_double ? OS_LAST_DOUBLE : OS_LAST_NORMAL;
    os_mid  = os_double ? OS_MID_DOUBLE : OS_MID_NORMAL;
    nbits = data_bits(s_r.cfg.character_size);
    rx_aligned = s_r.rx_shift >> (4'h9 - nbits);

    // slave clock: two sync flops, then edge detector
    s_nxt.ext_s1 = XCK_IN;
    s_nxt.ext_s2 = s_r.ext_s1;
    s_nxt.ext_prev = s_r.ext_s2;
    ext_rise = s_r.ext_s2 && !s_r.ext_prev;
    ext_fall = !s_r.ext_s2 && s_r.ext_prev;

    // master clock toggles every baud tick, half rate of tick
    s_nxt.xck_oe = sync_master;
    if (sync_master && baud_tick) begin
      s_nxt.transfer_clock_pin = !s_r.transfer_clock_pin;
    end else if (!sync_master) begin
      s_nxt.transfer_clock_pin = s_r.cfg.sync_clock_polarity;
    end

    // change and sample edges by polarity
    if (sync_master) begin
      chg_edge = baud_tick && (s_r.transfer_clock_pin == s_r.cfg.sync_clock_polarity);
      smp_edge = baud_tick && (s_r.transfer_clock_pin != s_r.cfg.sync_clock_polarity);
    end else begin
      chg_edge = s_r.cfg.sync_clock_polarity ? ext_fall : ext_rise;
      smp_edge = s_r.cfg.sync_clock_polarity ? ext_rise : ext_fall;
    end

    // asynchronous transmit prescaler
    if (baud_tick) begin
      s_nxt.presc = (s_r.presc >= os_last) ? 4'h0 : s_r.presc + 4'h1;
    end
    if (s_r.cfg.sync_select) begin
      tx_tick = chg_edge;
    end else begin
      tx_tick = baud_tick && (s_r.presc >= os_last);
    end

    // receiver oversampling counter
    if (baud_tick && s_r.rx_state != RX_IDLE) begin
      s_nxt.rx_os = (s_r.rx_os >= os_last) ? 4'h0 : s_r.rx_os + 4'h1;
    end
    if (s_r.cfg.sync_select) begin
      rx_samp = smp_edge;
    end else begin
      rx_samp = baud_tick && (s_r.rx_os == os_mid);
    end

    // transmitter frame sequencer
    if (!s_r.tx_en) begin
      s_nxt.tx_state = TX_IDLE;
      s_nxt.txd = 1'b1;
    end else if (tx_tick) begin
      case (s_r.tx_state)
        TX_IDLE, TX_STOP2: begin
          if (s_r.tx_state == TX_STOP2) begin
            s_nxt.transmit_complete_flag = !s_r.tx_full;
          end
          if (s_r.tx_full) begin
            s_nxt.tx_shift = s_r.tx_buf;
            s_nxt.tx_parbit = parity_of(s_r.tx_buf, nbits, s_r.cfg.parity_mode);
            s_nxt.tx_full = 1'b0;
            s_nxt.tx_state = TX_START;
            s_nxt.txd = 1'b0;
          end else begin
            s_nxt.tx_state = TX_IDLE;
            s_nxt.txd = 1'b1;
          end
        end
        TX_START: begin
          s_nxt.tx_state = TX_DATA;
          s_nxt.tx_bit = 4'h0;
          s_nxt.txd = s_r.tx_shift[0];
        end
        TX_DATA: begin
          if (s_r.tx_bit == nbits - 4'h1) begin
            if (parity_on(s_r.cfg.parity_mode)) begin
              s_nxt.tx_state = TX_PAR;
              s_nxt.txd = s_r.tx_parbit;
            end else begin
              s_nxt.tx_state = TX_STOP1;
              s_nxt.txd = 1'b1;
            end
          end else begin
            s_nxt.tx_shift = s_r.tx_shift >> 1;
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            s_nxt.txd = s_r.tx_shift[1];
          end
        end
        TX_PAR: begin
          s_nxt.tx_state = TX_STOP1;
          s_nxt.txd = 1'b1;
        end
        TX_STOP1: begin
          if (s_r.cfg.stop_select) begin
            s_nxt.tx_state = TX_STOP2;
          end else begin
            s_nxt.transmit_complete_flag = !s_r.tx_full;
            if (s_r.tx_full) begin
              s_nxt.tx_shift = s_r.tx_buf;
              s_nxt.tx_parbit = parity_of(s_r.tx_buf, nbits, s_r.cfg.parity_mode);
              s_nxt.tx_full = 1'b0;
              s_nxt.tx_state = TX_START;
              s_nxt.txd = 1'b0;
            end else begin
              s_nxt.tx_state = TX_IDLE;
            end
          end
        end
        default: begin
          s_nxt.tx_state = TX_IDLE;
          s_nxt.txd = 1'b1;
        end
      endcase
    end

    // receiver frame sequencer
    if (!s_r.rx_en) begin
      s_nxt.rx_state = RX_IDLE;
    end else begin
      case (s_r.rx_state)
        RX_IDLE: begin
          if (s_r.cfg.sync_select) begin
            if (smp_edge && !RXD_IN) begin
              s_nxt.rx_state = RX_DATA;
              s_nxt.rx_bit = 4'h0;
            end
          end else if (baud_tick && !RXD_IN) begin
            s_nxt.rx_state = RX_START;
            s_nxt.rx_os = 4'h1;
          end
        end
        RX_START: begin
          if (rx_samp) begin
            s_nxt.rx_state = RXD_IN ? RX_IDLE : RX_DATA;
            s_nxt.rx_bit = 4'h0;
          end
        end
        RX_DATA: begin
          if (rx_samp) begin
            s_nxt.rx_shift = {RXD_IN, s_r.rx_shift[CHAR_W-1:1]};
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
            if (s_r.rx_bit == nbits - 4'h1) begin
              s_nxt.rx_state = parity_on(s_r.cfg.parity_mode) ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rx_samp) begin
            s_nxt.rx_par = RXD_IN;
            s_nxt.rx_state = RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_samp) begin
            s_nxt.rx_data = rx_aligned;
            s_nxt.fe = !RXD_IN;
            s_nxt.pe = parity_on(s_r.cfg.parity_mode) &&
                       (s_r.rx_par != parity_of(rx_aligned, nbits, s_r.cfg.parity_mode));
            s_nxt.rx_state = RX_IDLE;
          end
        end
        default: begin
          s_nxt.rx_state = RX_IDLE;
        end
      endcase
    end

    // register writes
    if (WR_IN) begin
      if (ADDR_IN == ADDR_DIV_LOW) begin
        s_nxt.div_low = WDATA_IN;
      end else if (ADDR_IN == ADDR_DIV_HIGH) begin
        s_nxt.div_high = WDATA_IN[3:0];
      end else if (ADDR_IN == ADDR_CSA) begin
        s_nxt.cfg.double_speed = WDATA_IN[CSA_U2X];
        // a frame completing while the flag is clear wins over a write-one clear in the same cycle
        if (WDATA_IN[CSA_TXC] && !(s_nxt.transmit_complete_flag && !s_r.transmit_complete_flag)) begin
          s_nxt.transmit_complete_flag = 1'b0;
        end
      end else if (ADDR_IN == ADDR_CSB) begin
        s_nxt.rx_en = WDATA_IN[CSB_RXEN];
        s_nxt.tx_en = WDATA_IN[CSB_TXEN];
        s_nxt.cfg.character_size[2] = WDATA_IN[CSB_CS2];
        s_nxt.tx_b8 = WDATA_IN[CSB_TXB8];
      end else if (ADDR_IN == ADDR_CSC) begin
        s_nxt.cfg.sync_select = WDATA_IN[CSC_SYNC];
        s_nxt.cfg.parity_mode = WDATA_IN[CSC_PM1:CSC_PM0];
        s_nxt.cfg.stop_select = WDATA_IN[CSC_STOP];
        s_nxt.cfg.character_size[1:0] = WDATA_IN[CSC_CS1:CSC_CS0];
        s_nxt.cfg.sync_clock_polarity = WDATA_IN[CSC_POL];
      end else if (ADDR_IN == ADDR_SDR) begin
        s_nxt.tx_buf = {s_r.tx_b8, WDATA_IN};
        s_nxt.tx_full = 1'b1;
      end else if (ADDR_IN == ADDR_PIN_DIR) begin
        s_nxt.cfg.xfer_clock_pin_direction = WDATA_IN[PIN_DIR_BIT];
      end
    end

    // register reads, data in the following cycle only
    if (RD_IN) begin
      if (ADDR_IN == ADDR_DIV_LOW) begin
        rd_val = s_r.div_low;
      end else if (ADDR_IN == ADDR_DIV_HIGH) begin
        rd_val = {4'h0, s_r.div_high};
      end else if (ADDR_IN == ADDR_CSA) begin
        rd_val[CSA_RXC] = s_r.receive_complete_flag;
        rd_val[CSA_TXC] = s_r.transmit_complete_flag;
        rd_val[CSA_EMPTY] = !s_r.tx_full;
        rd_val[CSA_FE] = s_r.fe;
        rd_val[CSA_PE] = s_r.pe;
        rd_val[CSA_U2X] = s_r.cfg.double_speed;
      end else if (ADDR_IN == ADDR_CSB) begin
        rd_val[CSB_RXEN] = s_r.rx_en;
        rd_val[CSB_TXEN] = s_r.tx_en;
        rd_val[CSB_CS2] = s_r.cfg.character_size[2];
        rd_val[CSB_RXB8] = s_r.rx_data[8];
        rd_val[CSB_TXB8] = s_r.tx_b8;
      end else if (ADDR_IN == ADDR_CSC) begin
        rd_val[CSC_SYNC] = s_r.cfg.sync_select;
        rd_val[CSC_PM1:CSC_PM0] = s_r.cfg.parity_mode;
        rd_val[CSC_STOP] = s_r.cfg.stop_select;
        rd_val[CSC_CS1:CSC_CS0] = s_r.cfg.character_size[1:0];
        rd_val[CSC_POL] = s_r.cfg.sync_clock_polarity;
      end else if (ADDR_IN == ADDR_SDR) begin
        rd_val = s_r.rx_data[7:0];
        s_nxt.receive_complete_flag = 1'b0;
      end else if (ADDR_IN == ADDR_PIN_DIR) begin
        rd_val[PIN_DIR_BIT] = s_r.cfg.xfer_clock_pin_direction;
      end
    end
    s_nxt.rdata = rd_val;

    // a completing frame wins over a clear in the same cycle
    if (s_r.rx_en && s_r.rx_state == RX_STOP && rx_samp) begin
      s_nxt.receive_complete_flag = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      s_r <= '0;
      s_r.cfg.character_size <= CHAR_SIZE_RST;
      s_r.txd <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA_OUT  = s_r.rdata;
  assign TXD_OUT    = s_r.txd;
  assign XCK_OUT    = s_r.transfer_clock_pin;
  assign XCK_OE_OUT = s_r.xck_oe;

endmodule
`default_nettype wire

// ==== usart_clk_frame_asserts.sv ====
// port-level checker for the usart clock and frame block
`timescale 1ns/100ps
`default_nettype none
module usart_clk_frame_asserts
  import usart_clk_frame_pkg::*;
(
  input wire logic              CLK_IN,
  input wire logic              RSTN_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  input wire logic [DATA_W-1:0] WDATA_IN,
  input wire logic              WR_IN,
  input wire logic              RD_IN,
  input wire logic [DATA_W-1:0] RDATA_OUT,
  input wire logic              TXD_OUT,
  input wire logic              XCK_OUT,
  input wire logic              XCK_OE_OUT
);
  logic sync_r;
  logic dir_r;
  logic pol_r;
  logic mst;

  // shadow of the clock mode bits
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      sync_r <= 1'b0;
      pol_r  <= 1'b0;
      dir_r  <= 1'b0;
    end else if (WR_IN && ADDR_IN == ADDR_CSC) begin
      sync_r <= WDATA_IN[CSC_SYNC];
      pol_r  <= WDATA_IN[CSC_POL];
    end else if (WR_IN && ADDR_IN == ADDR_PIN_DIR) begin
      dir_r <= WDATA_IN[PIN_DIR_BIT];
    end
  end
  assign mst = sync_r & dir_r;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  reset_idle_a: assert property (disable iff (1'b0) !RSTN_IN |=> TXD_OUT && !XCK_OUT && !XCK_OE_OUT)
    else $error("outputs not idle after reset");
  rdata_quiet_a: assert property (!RD_IN |=> RDATA_OUT == 8'h00)
    else $error("read data outside read slot");
  unmapped_rd_a: assert property (RD_IN && ADDR_IN == 3'h7 |=> RDATA_OUT == 8'h00)
    else $error("unmapped address read not zero");
  oe_rise_a: assert property ($rose(mst) |-> ##[0:2] XCK_OE_OUT)
    else $error("clock pin not driven in master mode");
  oe_fall_a: assert property ($fell(mst) |-> ##[0:2] !XCK_OE_OUT)
    else $error("clock pin still driven outside master mode");
  oe_cause_a: assert property ($rose(XCK_OE_OUT) |-> mst)
    else $error("clock pin driven without master mode");
  idle_clk_a: assert property (!mst && !$past(mst) && !$past(WR_IN) |-> XCK_OUT == pol_r)
    else $error("idle clock level differs from polarity");
  start_width_a: assert property ($fell(TXD_OUT) |=> !TXD_OUT)
    else $error("low bit shorter than two cycles");

  cover property (mst && XCK_OE_OUT);
  cover property ($fell(TXD_OUT));
  cover property (RD_IN && ADDR_IN == 3'h7);
endmodule
`default_nettype wire

// ==== usart_peer.sv ====
// remote serial peer: captures transmitted frames, sends frames
`timescale 1ns/100ps
`default_nettype none
module usart_peer (
  input  wire logic clk_in,
  input  wire logic txd_in,
  output logic      rxd_out,
  output logic      xck_out
);
  initial begin
    rxd_out = 1'b1;
    xck_out = 1'b0;
  end

  // slave clock of eight cycles, well below a quarter of the core clock
  task automatic run_clock(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_in);
      xck_out <= ~xck_out;
    end
  endtask

  task automatic get_frame(input int n, input int bc, output logic [15:0] bits, output logic ok);
    int i;
    bits = 16'hFFFF;
    for (i = 0; i < 5000 && txd_in !== 1'b0; i++) @(posedge clk_in);
    repeat (bc / 2) @(posedge clk_in);
    ok = (txd_in === 1'b0);
    for (i = 0; i < n; i++) begin
      repeat (bc) @(posedge clk_in);
      bits[i] = txd_in;
    end
  endtask

  task automatic send_frame(input logic [15:0] bits, input int n, input int bc);
    int i;
    @(posedge clk_in);
    rxd_out <= 1'b0;
    repeat (bc) @(posedge clk_in);
    for (i = 0; i < n; i++) begin
      rxd_out <= bits[i];
      repeat (bc) @(posedge clk_in);
    end
    rxd_out <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== test_usart_clk_frame.sv ====
// self-checking bench for the usart clock and frame block
`timescale 1ns/100ps
`default_nettype none
module test_usart_clk_frame
  import usart_clk_frame_pkg::*;
;
  localparam logic [7:0] T_CSA [4] = '{8'h00, 8'h00, 8'h00, 8'h02};
  localparam logic [7:0] T_CSB [4] = '{8'h08, 8'h08, 8'h0D, 8'h08};
  localparam logic [7:0] T_CSC [4] = '{8'h00, 8'h2E, 8'h36, 8'h24};
  localparam logic [8:0] T_DAT [4] = '{9'h0F5, 9'h0A5, 9'h1C3, 9'h055};
  localparam int         T_ND  [4] = '{5, 8, 9, 7};

  logic              clk, rstn, wr_s, rd_s, rxd, transfer_clock_pin, txd, xck_o, xck_oe, ok;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [15:0]       got;
  int                error_cnt, samples_checked, n, bc, p;
  int                cyc = 0;

  usart_clk_frame dut_u (.CLK_IN(clk), .RSTN_IN(rstn), .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr_s),
    .RD_IN(rd_s), .RXD_IN(rxd), .XCK_IN(transfer_clock_pin), .RDATA_OUT(rdata), .TXD_OUT(txd), .XCK_OUT(xck_o),
    .XCK_OE_OUT(xck_oe));
  usart_peer peer_u (.clk_in(clk), .txd_in(txd), .rxd_out(rxd), .xck_out(transfer_clock_pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #10;
    chk({8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask

  // expected bits after the start bit, stops and beyond are ones
  function automatic logic [15:0] frame(input logic [8:0] d, input int nd, input logic [7:0] csc);
    logic [15:0] f;
    logic        par;
    f   = 16'hFFFF;
    par = csc[CSC_PM0];
    for (int i = 0; i < nd; i++) begin
      f[i] = d[i];
      par  = par ^ d[i];
    end
    if (csc[CSC_PM1]) f[nd] = par;
    return f;
  endfunction

  // full period of the clock pin, rise to rise
  task automatic xck_period(output int per);
    int i;
    for (i = 0; i < 50 && xck_o !== 1'b0; i++) @(posedge clk);
    for (i = 0; i < 50 && xck_o !== 1'b1; i++) @(posedge clk);
    for (per = 0; per < 50 && xck_o === 1'b1; per++) @(posedge clk);
    for (i = 0; i < 50 && xck_o !== 1'b1; i++) begin
      @(posedge clk);
      per++;
    end
  endtask

  initial begin
    rstn  = 1'b0;
    wr_s  = 1'b0;
    rd_s  = 1'b0;
    addr  = '0;
    wdata = '0;
    error_cnt       = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    rd(ADDR_DIV_LOW, 8'h00);
    rd(ADDR_CSA, 8'h20);
    rd(ADDR_CSB, 8'h04);
    rd(ADDR_CSC, 8'h04);
    wr(ADDR_DIV_HIGH, 8'h0A);
    rd(ADDR_DIV_HIGH, 8'h0A);
    wr(3'h7, 8'hFF);
    rd(3'h7, 8'h00);
    wr(ADDR_DIV_HIGH, 8'h00);
    wr(ADDR_DIV_LOW, 8'h02);
    $display("test registers done");

    for (int k = 0; k < 4; k++) begin
      wr(ADDR_CSA, T_CSA[k] | 8'h40);
      wr(ADDR_CSB, T_CSB[k]);
      wr(ADDR_CSC, T_CSC[k]);
      wr(ADDR_SDR, T_DAT[k][7:0]);
      n  = T_ND[k] + int'(T_CSC[k][CSC_PM1]) + int'(T_CSC[k][CSC_STOP]) + 1;
      bc = T_CSA[k][CSA_U2X] ? 24 : 48;
      peer_u.get_frame(n, bc, got, ok);
      chk({15'h0000, ok}, 16'h0001);
      chk(got, frame(T_DAT[k], T_ND[k], T_CSC[k]));
      repeat (bc) @(posedge clk);
      rd(ADDR_CSA, 8'h60 | T_CSA[k]);
    end
    $display("test transmit formats done");

    wr(ADDR_CSA, 8'h40);
    wr(ADDR_CSC, 8'h2E);
    wr(ADDR_CSB, 8'h10);
    peer_u.send_frame(frame(9'h03C, 8, 8'h2E), 11, 48);
    rd(ADDR_CSA, 8'hA0);
    rd(ADDR_SDR, 8'h3C);
    peer_u.send_frame(frame(9'h081, 8, 8'h2E) ^ 16'h0300, 11, 48);
    rd(ADDR_CSA, 8'hB4);
    rd(ADDR_SDR, 8'h81);
    wr(ADDR_CSB, 8'h00);
    $display("test receive done");

    wr(ADDR_PIN_DIR, 8'h01);
    wr(ADDR_CSC, 8'h46);
    wr(ADDR_CSB, 8'h08);
    chk({15'h0000, xck_oe}, 16'h0001);
    xck_period(p);
    chk(16'(p), 16'h0006);
    wr(ADDR_SDR, 8'h5A);
    peer_u.get_frame(9, 6, got, ok);
    chk(got, frame(9'h05A, 8, 8'h46));
    repeat (12) @(posedge clk);
    wr(ADDR_CSC, 8'h47);
    wr(ADDR_PIN_DIR, 8'h00);
    repeat (2) @(posedge clk);
    chk({14'h0000, xck_oe, xck_o}, 16'h0001);
    $display("test synchronous master done");

    // slave: peer clocks eight cycles a bit, data changes on falling edges
    wr(ADDR_SDR, 8'h3C);
    fork
      peer_u.run_clock(30);
      peer_u.get_frame(9, 8, got, ok);
    join
    chk({15'h0000, ok}, 16'h0001);
    chk(got, frame(9'h03C, 8, 8'h47));
    $display("test synchronous slave done");
    end_sim();
  end
endmodule

bind usart_clk_frame usart_clk_frame_asserts chk_u (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .ADDR_IN(ADDR_IN),
  .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .TXD_OUT(TXD_OUT),
  .XCK_OUT(XCK_OUT), .XCK_OE_OUT(XCK_OE_OUT));
`default_nettype wire
